//--- include/btl_pkg.sv
// shared constants and types of the branch trace store logger
package btl_pkg;

  // register port
  localparam int unsigned REG_AW = 8;
  localparam logic [7:0] OFS_DEBUG_CTL = 8'h00;
  localparam logic [7:0] OFS_AREA_PTR = 8'h04;
  localparam logic [7:0] OFS_MISC_EN = 8'h08;
  localparam logic [7:0] OFS_LER_SRC = 8'h0c;
  localparam logic [7:0] OFS_LER_TGT = 8'h10;
  localparam logic [7:0] OFS_IDENT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // debug control bits
  localparam int unsigned BIT_TR = 2;
  localparam int unsigned BIT_STB = 3;
  localparam int unsigned BIT_BIE = 4;

  // misc enable and identification bits
  localparam int unsigned BIT_UNAVAIL = 11;
  localparam int unsigned BIT_DS_FEAT = 21;

  // status bits; the three flags clear on a written one
  localparam int unsigned STS_BUF_IRQ = 0;
  localparam int unsigned STS_SAMPLE = 1;
  localparam int unsigned STS_PRECISE = 2;
  localparam int unsigned STS_BUSY = 3;

  // management area layout, byte offsets from the area pointer
  localparam logic [31:0] FLD_BASE_OFS = 32'h0000_0000;
  localparam logic [31:0] FLD_INDEX_OFS = 32'h0000_0004;
  localparam logic [31:0] FLD_MAX_OFS = 32'h0000_0008;
  localparam logic [31:0] FLD_THRESH_OFS = 32'h0000_000c;

  // field store slots
  localparam int unsigned FLD_COUNT = 4;
  localparam logic [1:0] FLD_BASE = 2'h0;
  localparam logic [1:0] FLD_INDEX = 2'h1;
  localparam logic [1:0] FLD_MAX = 2'h2;
  localparam logic [1:0] FLD_THRESH = 2'h3;

  // branch record in memory: source, target, kind word
  localparam logic [31:0] REC_TO_OFS = 32'h0000_0004;
  localparam logic [31:0] REC_FLAG_OFS = 32'h0000_0008;
  localparam logic [31:0] REC_BYTES = 32'h0000_000c;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD_BASE,
    ST_RD_INDEX,
    ST_RD_MAX,
    ST_RD_THRESH,
    ST_DECIDE,
    ST_WR_FROM,
    ST_WR_TO,
    ST_WR_FLAG,
    ST_WR_INDEX
  } btl_state_t;

endpackage : btl_pkg

//--- src/btl_field_store.sv
// holds the four management area fields fetched for the current record
`timescale 1ns/10ps
module btl_field_store (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [1:0] waddr,
  input wire logic [31:0] wdata,
  output logic [btl_pkg::FLD_COUNT-1:0][31:0] q
);

  typedef struct packed {
    logic [btl_pkg::FLD_COUNT-1:0][31:0] word;
  } btl_fs_state_t;

  btl_fs_state_t s_r;
  btl_fs_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.word[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // read data are the stored words themselves, so they come straight from flops
  assign q = s_r.word;

endmodule : btl_field_store

//--- src/btl_logger.sv
// branch trace store logger: control registers, last exception record, buffer writer
`timescale 1ns/10ps
module btl_logger #(
  parameter logic STORE_UNAVAIL = 1'b0,
  parameter logic DS_PRESENT = 1'b1
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [btl_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic EVT_VALID,
  input wire logic [31:0] EVT_FROM,
  input wire logic [31:0] EVT_TO,
  input wire logic EVT_EXC,
  output logic EVT_READY,
  output logic BTM_VALID,
  output logic [31:0] BTM_FROM,
  output logic [31:0] BTM_TO,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic SAMPLE_OVF,
  input wire logic PRECISE_HIT,
  output logic DS_IRQ
);

  typedef struct packed {
    logic trace_msg_enable;
    logic store_to_buffer;
    logic buffer_full_irq_enable;
    logic [31:0] store_area_pointer;
    logic [31:0] ler_src;
    logic [31:0] ler_tgt;
    logic [31:0] lb_from;
    logic [31:0] lb_to;
    btl_pkg::btl_state_t st;
    logic [31:0] rec_from;
    logic [31:0] rec_to;
    logic rec_exc;
    logic [31:0] widx;
    logic buf_irq;
    logic samp_flag;
    logic prec_flag;
    logic irq;
    logic [31:0] rdata;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic btm_valid;
    logic [31:0] btm_from;
    logic [31:0] btm_to;
    logic ready;
  } btl_logger_state_t;

  btl_logger_state_t s_r;
  btl_logger_state_t s_nxt;

  logic fs_we;
  logic [1:0] fs_waddr;
  logic [btl_pkg::FLD_COUNT-1:0][31:0] fs_q;

  btl_field_store u_fields (
    .clk(CLK_SYS),
    .nrst(NRST),
    .we(fs_we),
    .waddr(fs_waddr),
    .wdata(MEM_RDATA),
    .q(fs_q)
  );

  // address of a management area field, used for every fetch and the index write-back
  function automatic logic [31:0] area_addr(input logic [31:0] ptr, input logic [31:0] ofs);
    area_addr = ptr + ofs;
  endfunction : area_addr

  // register read mux
  function automatic logic [31:0] reg_read(input btl_logger_state_t s,
                                           input logic [btl_pkg::REG_AW-1:0] addr);
    logic [31:0] v;
    v = '0;
    unique case (addr)
      btl_pkg::OFS_DEBUG_CTL: begin
        v[btl_pkg::BIT_TR] = s.trace_msg_enable;
        v[btl_pkg::BIT_STB] = s.store_to_buffer;
        v[btl_pkg::BIT_BIE] = s.buffer_full_irq_enable;
      end
      btl_pkg::OFS_AREA_PTR: begin
        v = s.store_area_pointer;
      end
      btl_pkg::OFS_MISC_EN: begin
        v[btl_pkg::BIT_UNAVAIL] = STORE_UNAVAIL;
      end
      btl_pkg::OFS_LER_SRC: begin
        v = s.ler_src;
      end
      btl_pkg::OFS_LER_TGT: begin
        v = s.ler_tgt;
      end
      btl_pkg::OFS_IDENT: begin
        v[btl_pkg::BIT_DS_FEAT] = DS_PRESENT;
      end
      btl_pkg::OFS_STATUS: begin
        v[btl_pkg::STS_BUF_IRQ] = s.buf_irq;
        v[btl_pkg::STS_SAMPLE] = s.samp_flag;
        v[btl_pkg::STS_PRECISE] = s.prec_flag;
        v[btl_pkg::STS_BUSY] = (s.st != btl_pkg::ST_IDLE);
      end
      default: begin
        v = '0;
      end
    endcase
    reg_read = v;
  endfunction : reg_read

  always_comb begin
    s_nxt = s_r;
    s_nxt.btm_valid = 1'b0;
    s_nxt.rdata = '0;
    fs_we = 1'b0;
    fs_waddr = btl_pkg::FLD_BASE;

    if (REG_RD) begin
      s_nxt.rdata = reg_read(s_r, REG_ADDR);
    end

    if (REG_WR) begin
      unique case (REG_ADDR)
        btl_pkg::OFS_DEBUG_CTL: begin
          s_nxt.trace_msg_enable = REG_WDATA[btl_pkg::BIT_TR];
          // store and interrupt enables stay zero while the facility is absent
          if (!STORE_UNAVAIL) begin
            s_nxt.store_to_buffer = REG_WDATA[btl_pkg::BIT_STB];
            s_nxt.buffer_full_irq_enable = REG_WDATA[btl_pkg::BIT_BIE];
          end
        end
        btl_pkg::OFS_AREA_PTR: begin
          s_nxt.store_area_pointer = REG_WDATA;
        end
        btl_pkg::OFS_STATUS: begin
          if (REG_WDATA[btl_pkg::STS_BUF_IRQ]) begin
            s_nxt.buf_irq = 1'b0;
          end
          if (REG_WDATA[btl_pkg::STS_SAMPLE]) begin
            s_nxt.samp_flag = 1'b0;
          end
          if (REG_WDATA[btl_pkg::STS_PRECISE]) begin
            s_nxt.prec_flag = 1'b0;
          end
        end
        default: begin
          s_nxt.store_area_pointer = s_r.store_area_pointer;
        end
      endcase
    end

    // sets come after the clears so that a coincident event is kept
    if (SAMPLE_OVF) begin
      s_nxt.samp_flag = 1'b1;
    end
    if (PRECISE_HIT) begin
      s_nxt.prec_flag = 1'b1;
    end

    // event capture; ready is low from reset until the first clock edge and while a buffer record is in flight
    if (EVT_VALID && s_r.ready) begin
      if (EVT_EXC) begin
        s_nxt.ler_src = s_r.lb_from;
        s_nxt.ler_tgt = s_r.lb_to;
      end
      s_nxt.lb_from = EVT_FROM;
      s_nxt.lb_to = EVT_TO;
      if (s_r.trace_msg_enable) begin
        if (!s_r.store_to_buffer) begin
          s_nxt.btm_valid = 1'b1;
          s_nxt.btm_from = EVT_FROM;
          s_nxt.btm_to = EVT_TO;
        end else begin
          s_nxt.rec_from = EVT_FROM;
          s_nxt.rec_to = EVT_TO;
          s_nxt.rec_exc = EVT_EXC;
          s_nxt.st = btl_pkg::ST_RD_BASE;
          s_nxt.mem_req = 1'b1;
          s_nxt.mem_we = 1'b0;
          s_nxt.mem_addr = area_addr(s_r.store_area_pointer, btl_pkg::FLD_BASE_OFS);
        end
      end
    end

    // fields are fetched afresh per record, so a handler that rewinds the index is seen
    unique case (s_r.st)
      btl_pkg::ST_IDLE: begin
        s_nxt.mem_wdata = s_r.mem_wdata;
      end
      btl_pkg::ST_RD_BASE: begin
        if (MEM_ACK) begin
          fs_we = 1'b1;
          fs_waddr = btl_pkg::FLD_BASE;
          s_nxt.st = btl_pkg::ST_RD_INDEX;
          s_nxt.mem_addr = area_addr(s_r.store_area_pointer, btl_pkg::FLD_INDEX_OFS);
        end
      end
      btl_pkg::ST_RD_INDEX: begin
        if (MEM_ACK) begin
          fs_we = 1'b1;
          fs_waddr = btl_pkg::FLD_INDEX;
          s_nxt.st = btl_pkg::ST_RD_MAX;
          s_nxt.mem_addr = area_addr(s_r.store_area_pointer, btl_pkg::FLD_MAX_OFS);
        end
      end
      btl_pkg::ST_RD_MAX: begin
        if (MEM_ACK) begin
          fs_we = 1'b1;
          fs_waddr = btl_pkg::FLD_MAX;
          s_nxt.st = btl_pkg::ST_RD_THRESH;
          s_nxt.mem_addr = area_addr(s_r.store_area_pointer, btl_pkg::FLD_THRESH_OFS);
        end
      end
      btl_pkg::ST_RD_THRESH: begin
        if (MEM_ACK) begin
          fs_we = 1'b1;
          fs_waddr = btl_pkg::FLD_THRESH;
          s_nxt.st = btl_pkg::ST_DECIDE;
          s_nxt.mem_req = 1'b0;
        end
      end
      btl_pkg::ST_DECIDE: begin
        if (fs_q[btl_pkg::FLD_INDEX] >= fs_q[btl_pkg::FLD_MAX]) begin
          if (s_r.buffer_full_irq_enable) begin
            // record dropped, enables left as programmed
            s_nxt.st = btl_pkg::ST_IDLE;
            s_nxt.buf_irq = 1'b1;
          end else begin
            s_nxt.widx = fs_q[btl_pkg::FLD_BASE];
            s_nxt.st = btl_pkg::ST_WR_FROM;
            s_nxt.mem_req = 1'b1;
            s_nxt.mem_we = 1'b1;
            s_nxt.mem_addr = fs_q[btl_pkg::FLD_BASE];
            s_nxt.mem_wdata = s_r.rec_from;
          end
        end else begin
          s_nxt.widx = fs_q[btl_pkg::FLD_INDEX];
          s_nxt.st = btl_pkg::ST_WR_FROM;
          s_nxt.mem_req = 1'b1;
          s_nxt.mem_we = 1'b1;
          s_nxt.mem_addr = fs_q[btl_pkg::FLD_INDEX];
          s_nxt.mem_wdata = s_r.rec_from;
        end
      end
      btl_pkg::ST_WR_FROM: begin
        if (MEM_ACK) begin
          s_nxt.st = btl_pkg::ST_WR_TO;
          s_nxt.mem_addr = s_r.widx + btl_pkg::REC_TO_OFS;
          s_nxt.mem_wdata = s_r.rec_to;
        end
      end
      btl_pkg::ST_WR_TO: begin
        if (MEM_ACK) begin
          s_nxt.st = btl_pkg::ST_WR_FLAG;
          s_nxt.mem_addr = s_r.widx + btl_pkg::REC_FLAG_OFS;
          s_nxt.mem_wdata = {31'h0, s_r.rec_exc};
        end
      end
      btl_pkg::ST_WR_FLAG: begin
        if (MEM_ACK) begin
          s_nxt.st = btl_pkg::ST_WR_INDEX;
          s_nxt.mem_addr = area_addr(s_r.store_area_pointer, btl_pkg::FLD_INDEX_OFS);
          s_nxt.mem_wdata = s_r.widx + btl_pkg::REC_BYTES;
          if (s_r.buffer_full_irq_enable &&
              (s_r.widx + btl_pkg::REC_BYTES >= fs_q[btl_pkg::FLD_THRESH])) begin
            s_nxt.buf_irq = 1'b1;
          end
        end
      end
      btl_pkg::ST_WR_INDEX: begin
        if (MEM_ACK) begin
          s_nxt.st = btl_pkg::ST_IDLE;
          s_nxt.mem_req = 1'b0;
          s_nxt.mem_we = 1'b0;
        end
      end
      // a code outside the enum can only come from an upset; fall back to idle
      default: begin
        s_nxt.st = btl_pkg::ST_IDLE;
        s_nxt.mem_req = 1'b0;
        s_nxt.mem_we = 1'b0;
      end
    endcase

    // one shared line for all three sources; software tells them apart by status
    s_nxt.irq = s_nxt.buf_irq | s_nxt.samp_flag | s_nxt.prec_flag;
    s_nxt.ready = (s_nxt.st == btl_pkg::ST_IDLE);
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign EVT_READY = s_r.ready;
  assign BTM_VALID = s_r.btm_valid;
  assign BTM_FROM = s_r.btm_from;
  assign BTM_TO = s_r.btm_to;
  assign MEM_REQ = s_r.mem_req;
  assign MEM_WE = s_r.mem_we;
  assign MEM_ADDR = s_r.mem_addr;
  assign MEM_WDATA = s_r.mem_wdata;
  assign DS_IRQ = s_r.irq;

endmodule : btl_logger

//--- test/btl_logger_props.sv
// port-level checks of the branch trace store logger
`timescale 1ns/10ps
module btl_logger_props #(
  parameter logic STORE_UNAVAIL = 1'b0,
  parameter logic DS_PRESENT = 1'b1
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [btl_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic EVT_VALID,
  input wire logic [31:0] EVT_FROM,
  input wire logic [31:0] EVT_TO,
  input wire logic EVT_EXC,
  input wire logic EVT_READY,
  input wire logic BTM_VALID,
  input wire logic [31:0] BTM_FROM,
  input wire logic [31:0] BTM_TO,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic SAMPLE_OVF,
  input wire logic DS_IRQ
);
  logic [31:0] ctl_r, area_r, pf_r, ls_r;
  logic acc, buf_on;
  assign acc = EVT_VALID && EVT_READY;
  assign buf_on = ctl_r[2] && ctl_r[3];
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // mirror of software's writes; store bits cannot stick when the store is unavailable
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctl_r <= '0;
      area_r <= '0;
      pf_r <= '0;
      ls_r <= '0;
    end else begin
      if (REG_WR && REG_ADDR == btl_pkg::OFS_DEBUG_CTL)
        ctl_r <= REG_WDATA & (STORE_UNAVAIL ? 32'h0000_0004 : 32'h0000_001c);
      if (REG_WR && REG_ADDR == btl_pkg::OFS_AREA_PTR)
        area_r <= REG_WDATA;
      if (acc) begin
        pf_r <= EVT_FROM;
        if (EVT_EXC)
          ls_r <= pf_r;
      end
    end
  end
  AST_ONE_DEST: assert property (!(BTM_VALID && MEM_REQ))
    else $error("message and buffer write at once");
  AST_TRACE_OFF: assert property (acc && !ctl_r[2] |=> !BTM_VALID && !MEM_REQ)
    else $error("output with trace off");
  AST_BUS_MSG: assert property (acc && ctl_r[2] && !ctl_r[3] |=> BTM_VALID
    && BTM_FROM == $past(EVT_FROM) && BTM_TO == $past(EVT_TO)) else $error("bad bus message");
  AST_BUF_START: assert property (acc && buf_on |=> MEM_REQ && !MEM_WE
    && MEM_ADDR == area_r && !EVT_READY) else $error("buffer record not started at area");
  AST_REQ_HOLD: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR)
    && $stable(MEM_WE) && $stable(MEM_WDATA)) else $error("memory request changed early");
  AST_IDENT: assert property (REG_RD && REG_ADDR == btl_pkg::OFS_IDENT
    |=> REG_RDATA[21] == DS_PRESENT) else $error("feature bit wrong");
  AST_CTL_KEPT: assert property (REG_RD && REG_ADDR == btl_pkg::OFS_DEBUG_CTL
    |=> REG_RDATA[4:2] == ctl_r[4:2]) else $error("control bits changed");
  AST_LER_SRC: assert property (REG_RD && !acc && REG_ADDR == btl_pkg::OFS_LER_SRC
    |=> REG_RDATA == ls_r) else $error("last exception source wrong");
  AST_OVF_IRQ: assert property ($rose(SAMPLE_OVF) |-> ##[1:2] DS_IRQ)
    else $error("sampling overflow not signalled");
  COV_BUS: cover property (BTM_VALID ##1 BTM_VALID);
  COV_WR: cover property (MEM_REQ && MEM_WE && MEM_ACK);
  COV_IRQ: cover property ($rose(DS_IRQ));
endmodule : btl_logger_props
bind btl_logger btl_logger_props #(.STORE_UNAVAIL(STORE_UNAVAIL), .DS_PRESENT(DS_PRESENT)) chk (.*);

//--- test/btl_mem_model.sv
// memory partner answering the logger's buffer requests
`timescale 1ns/10ps
module btl_mem_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic slow,
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem [128];
  logic [1:0] wait_r;
  // read data flips outside answers so a stale word never passes for a fresh one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      wait_r <= 2'h0;
      rdata <= '0;
    end else begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack) begin
        if (wait_r == (slow ? 2'h2 : 2'h0)) begin
          ack <= 1'b1;
          wait_r <= 2'h0;
          rdata <= mem[addr[8:2]];
          if (we)
            mem[addr[8:2]] <= wdata;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule : btl_mem_model

//--- test/tb_btl_logger.sv
// self-checking bench of the branch trace store logger
`timescale 1ns/10ps
`define CHK(a, e) chk((a), (e));
module tb_btl_logger;
  logic CLK_SYS = 1'b0, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, rd_d = 1'b0;
  logic EVT_VALID = 1'b0, EVT_EXC = 1'b0, SAMPLE_OVF = 1'b0, PRECISE_HIT = 1'b0;
  logic MEM_REQ, MEM_WE, MEM_ACK, EVT_READY, BTM_VALID, DS_IRQ, slow = 1'b0, irq_mode;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = '0, EVT_FROM = '0, EVT_TO = '0, REG_RDATA, BTM_FROM, BTM_TO;
  logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, seed = 32'h0000_1fd8, idx, bs, mx, f, t;
  logic [31:0] expq[$];
  logic irq_d = 1'b0;
  logic [31:0] irq_seen = '0;
  int error_cnt = 0, checks = 0;
  always #2.5 CLK_SYS = ~CLK_SYS;
  btl_logger uut (.*);
  btl_mem_model mdl (.clk(CLK_SYS), .nrst(NRST), .req(MEM_REQ), .we(MEM_WE),
    .addr(MEM_ADDR), .wdata(MEM_WDATA), .slow(slow), .ack(MEM_ACK), .rdata(MEM_RDATA));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // arguments are evaluated once, so a queue pop happens at most once per compare
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic end_sim();
    if (expq.size() != 0) begin
      error_cnt++;
      $display("unexpected at %0t: %0d expected results never seen", $time, expq.size());
    end
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    cyc(1);
    REG_WR <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    cyc(1);
    REG_RD <= 1'b0;
    cyc(1);
  endtask : rd
  // holds the event until ready reads high after an edge, the edge that takes it; rec then waits out a buffer record; the caller lowers valid after a burst
  task automatic ev(input logic [31:0] ef, input logic [31:0] et, input logic x, input logic bus);
    int i;
    EVT_VALID <= 1'b1;
    EVT_FROM <= ef;
    EVT_TO <= et;
    EVT_EXC <= x;
    if (bus) begin
      expq.push_back(ef);
      expq.push_back(et);
    end
    for (i = 0; i < 50; i++) begin
      cyc(1);
      if (EVT_READY === 1'b1)
        break;
    end
    if (i == 50) begin
      error_cnt++;
      $display("unexpected at %0t: event never accepted", $time);
      end_sim();
    end
  endtask : ev
  task automatic rec(input logic [31:0] ef, input logic [31:0] et, input logic x);
    int i;
    if (idx >= mx && !irq_mode)
      idx = bs;
    if (idx < mx) begin
      expq.push_back(ef);
      expq.push_back(et);
      expq.push_back({31'h0, x});
      expq.push_back(idx + 32'h0000_000c);
      idx += 32'h0000_000c;
    end
    ev(ef, et, x, 1'b0);
    EVT_VALID <= 1'b0;
    cyc(2);
    for (i = 0; i < 200 && EVT_READY !== 1'b1; i++)
      cyc(1);
    if (i == 200) begin
      error_cnt++;
      $display("unexpected at %0t: buffer record never finished", $time);
      end_sim();
    end
  endtask : rec
  // area at 0x40, buffer from 0x80 up to 0x98, with a gap after the area; base aligned,
  // bit 20 clear, size a whole number of records
  task automatic setup(input logic [31:0] th, input logic im);
    bs = 32'h0000_0080;
    mx = 32'h0000_0098;
    idx = bs;
    irq_mode = im;
    mdl.mem[16] = bs;
    mdl.mem[17] = bs;
    mdl.mem[18] = mx;
    mdl.mem[19] = th;
  endtask : setup
  always @(posedge CLK_SYS) begin
    if (rd_d)
      `CHK(REG_RDATA, expq.size() ? expq.pop_front() : ~REG_RDATA)
    if (BTM_VALID === 1'b1) begin
      `CHK(BTM_FROM, expq.size() ? expq.pop_front() : ~BTM_FROM)
      `CHK(BTM_TO, expq.size() ? expq.pop_front() : ~BTM_TO)
    end
    if ((MEM_REQ && MEM_WE && MEM_ACK) === 1'b1)
      `CHK(MEM_WDATA, expq.size() ? expq.pop_front() : ~MEM_WDATA)
    // counted on rising edges only, as a fixed, edge-sensitive interrupt entry sees them
    if (DS_IRQ === 1'b1 && irq_d === 1'b0)
      irq_seen <= irq_seen + 32'h1;
    irq_d <= DS_IRQ;
    rd_d <= REG_RD;
  end
  initial begin
    cyc(20);
    NRST <= 1'b1;
    cyc(2);
    rd(btl_pkg::OFS_IDENT, 32'h0020_0000);
    wr(btl_pkg::OFS_IDENT, '1);
    rd(btl_pkg::OFS_IDENT, 32'h0020_0000);
    rd(btl_pkg::OFS_MISC_EN, '0);
    rd(8'h1c, '0);
    wr(btl_pkg::OFS_AREA_PTR, 32'h0000_0040);
    rd(btl_pkg::OFS_AREA_PTR, 32'h0000_0040);
    wr(btl_pkg::OFS_DEBUG_CTL, 32'h0000_0018);
    f = rnd();
    t = rnd();
    ev(f, t, 1'b0, 1'b0);
    ev(rnd(), rnd(), 1'b1, 1'b0);
    EVT_VALID <= 1'b0;
    cyc(2);
    rd(btl_pkg::OFS_LER_SRC, f);
    rd(btl_pkg::OFS_LER_TGT, t);
    wr(btl_pkg::OFS_DEBUG_CTL, 32'h0000_0014);
    for (int i = 0; i < 6; i++)
      ev(rnd(), rnd(), i[0], 1'b1);
    EVT_VALID <= 1'b0;
    cyc(3);
    wr(btl_pkg::OFS_DEBUG_CTL, 32'h0000_000c);
    setup(32'h0000_0098, 1'b0);
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      rec(rnd(), rnd(), i[1]);
    end
    wr(btl_pkg::OFS_DEBUG_CTL, 32'h0000_001c);
    setup(32'h0000_008c, 1'b1);
    rec(rnd(), rnd(), 1'b0);
    wr(btl_pkg::OFS_DEBUG_CTL, 32'h0000_0018);
    rd(btl_pkg::OFS_STATUS, 32'h0000_0001);
    wr(btl_pkg::OFS_STATUS, 32'h0000_0001);
    wr(btl_pkg::OFS_DEBUG_CTL, 32'h0000_001c);
    rd(btl_pkg::OFS_STATUS, '0);
    rec(rnd(), rnd(), 1'b1);
    wr(btl_pkg::OFS_STATUS, 32'h0000_0001);
    rec(rnd(), rnd(), 1'b0);
    rd(btl_pkg::OFS_STATUS, 32'h0000_0001);
    rd(btl_pkg::OFS_DEBUG_CTL, 32'h0000_001c);
    wr(btl_pkg::OFS_STATUS, 32'h0000_0001);
    for (int k = 1; k < 3; k++) begin
      SAMPLE_OVF <= (k == 1);
      PRECISE_HIT <= (k == 2);
      cyc(1);
      SAMPLE_OVF <= 1'b0;
      PRECISE_HIT <= 1'b0;
      cyc(2);
      rd(btl_pkg::OFS_STATUS, 32'h1 << k);
      wr(btl_pkg::OFS_STATUS, 32'h1 << k);
    end
    cyc(5);
    // buffer twice near full, one drop, one sampling and one precise cause
    `CHK(irq_seen, 32'h0000_0005)
    end_sim();
  end
endmodule : tb_btl_logger
